/* core/imap_defines.svh */
`ifndef IMAP_DEFINES_SVH
`define IMAP_DEFINES_SVH

// request numbers of the lower maskable map
`define IMAP_IRQ_VTIMER_TWO 27
`define IMAP_IRQ_VTIMER_THREE 26
`define IMAP_IRQ_VTIMER_FOUR 25
`define IMAP_IRQ_SSP 24
`define IMAP_IRQ_UART0_TX 23
`define IMAP_IRQ_UART0_CTS 22
`define IMAP_IRQ_CAN1 21
`define IMAP_IRQ_UART1_RX 20
`define IMAP_IRQ_UART1_TX 19
`define IMAP_IRQ_UART2_RX 18
`define IMAP_IRQ_UART2_TX 17
`define IMAP_IRQ_UART3_RX 16
`define IMAP_IRQ_UART3_TX 15
`define IMAP_IRQ_ADC_DONE 13
`define IMAP_IRQ_WAKEUP_0 12
`define IMAP_IRQ_RNG 3
`define IMAP_IRQ_FLASH 1

// widths and reset values
`define IMAP_NUM_W 5
`define IMAP_VEC_W 32
`define IMAP_EN_W 16
`define IMAP_DEPTH_W 8
`define IMAP_RST_VEC 32'h0000_0000
`define IMAP_RST_NUM 5'h00
`define IMAP_RST_DEPTH 8'h00

`endif

/* core/imap_enc_if.sv */
`timescale 1ns/10ps
`include "imap_defines.svh"

interface imap_enc_if;
    import imap_pkg::*;
    imap_req_vec_type pending;
    logic any;
    imap_irq_num_type num;
    modport enc (input pending, output any, output num);
    modport user (output pending, input any, input num);
endinterface : imap_enc_if

/* core/imap_interrupt_source_map.sv */
`timescale 1ns/10ps
`include "imap_defines.svh"

// Contract
// - non-maskable requests always nest, never disabled
// - handler entry clears global maskable enable
// - load processor register write loads global enable from its I bit
// - each source gated by its own enable
// - no depth limit, only stack availability
// - uart0 tx 23, cts 22, can1 21
// - uart1 rx/tx 20/19, uart2 18/17
// - vtimer four 25, serial peripheral 24
// - vtimer two maps to 27
// - vtimer three maps to 26
// - random number generator maps to 3
module imap_interrupt_source_map
    import imap_pkg::*;
#(
    parameter int DEPTH_W = `IMAP_DEPTH_W
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // peripheral request levels
    input wire logic VTIMER_REQUEST_TWO,
    input wire logic VTIMER_REQUEST_THREE,
    input wire logic VTIMER_REQUEST_FOUR,
    input wire logic SSP_REQ,
    input wire logic UART0_TX_REQ,
    input wire logic UART0_CTS_REQ,
    input wire logic CAN1_REQ,
    input wire logic UART1_RX_REQ,
    input wire logic UART1_TX_REQ,
    input wire logic UART2_RX_REQ,
    input wire logic UART2_TX_REQ,
    input wire logic UART3_RX_REQ,
    input wire logic UART3_TX_REQ,
    input wire logic ADC_DONE_REQ,
    input wire logic [7:0] MULTI_INPUT_WAKEUP_UNIT_REQ,
    input wire logic RNG_REQ,
    input wire logic FLASH_REQ,
    input wire logic NMI_REQ_IN,
    // source enables held by the core
    input wire logic [`IMAP_EN_W-1:0] SOURCE_ENABLE_LOW,
    input wire logic [`IMAP_EN_W-1:0] SOURCE_ENABLE_HIGH,
    // core control
    input wire logic LOAD_PROCESSOR_REGISTER_INSTR_WR,
    input wire logic LOAD_PROCESSOR_REGISTER_INSTR_I,
    input wire logic ENTRY_ACK,
    input wire logic HANDLER_RETURN,
    input wire logic RETURN_I,
    input wire logic STACK_AVAIL,
    // requests and status to the core
    output logic INT_REQ,
    output logic [`IMAP_NUM_W-1:0] INT_NUM,
    output logic NMI_REQ,
    output logic GLOBAL_ENABLE,
    output logic [DEPTH_W-1:0] NEST_DEPTH
);
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic rst_n;

    imap_req_vec_type raw_vec;
    imap_req_vec_type en_vec;
    imap_req_vec_type pend_reg, pend_next;
    logic i_bit_reg, i_bit_next;
    logic int_req_reg, int_req_next;
    logic nmi_reg, nmi_next;
    imap_irq_num_type num_reg, num_next;
    logic [DEPTH_W-1:0] depth_reg, depth_next;

    imap_enc_if enc_bus ();

    // reset released through two flops; assertion stays asynchronous
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    // source map; unused numbers stay zero so a spurious number never appears
    always_comb begin
        raw_vec = `IMAP_RST_VEC;
        raw_vec[`IMAP_IRQ_VTIMER_TWO] = VTIMER_REQUEST_TWO;
        raw_vec[`IMAP_IRQ_VTIMER_THREE] = VTIMER_REQUEST_THREE;
        raw_vec[`IMAP_IRQ_VTIMER_FOUR] = VTIMER_REQUEST_FOUR;
        raw_vec[`IMAP_IRQ_SSP] = SSP_REQ;
        raw_vec[`IMAP_IRQ_UART0_TX] = UART0_TX_REQ;
        raw_vec[`IMAP_IRQ_UART0_CTS] = UART0_CTS_REQ;
        raw_vec[`IMAP_IRQ_CAN1] = CAN1_REQ;
        raw_vec[`IMAP_IRQ_UART1_RX] = UART1_RX_REQ;
        raw_vec[`IMAP_IRQ_UART1_TX] = UART1_TX_REQ;
        raw_vec[`IMAP_IRQ_UART2_RX] = UART2_RX_REQ;
        raw_vec[`IMAP_IRQ_UART2_TX] = UART2_TX_REQ;
        raw_vec[`IMAP_IRQ_UART3_RX] = UART3_RX_REQ;
        raw_vec[`IMAP_IRQ_UART3_TX] = UART3_TX_REQ;
        raw_vec[`IMAP_IRQ_ADC_DONE] = ADC_DONE_REQ;
        for (int w = 0; w < 8; w++) begin
            raw_vec[`IMAP_IRQ_WAKEUP_0 - w] = MULTI_INPUT_WAKEUP_UNIT_REQ[w];
        end
        raw_vec[`IMAP_IRQ_RNG] = RNG_REQ;
        raw_vec[`IMAP_IRQ_FLASH] = FLASH_REQ;
    end

    assign en_vec = {SOURCE_ENABLE_HIGH, SOURCE_ENABLE_LOW};

    assign enc_bus.pending = pend_reg;

    imap_prio_enc #(
        .WIDTH(`IMAP_VEC_W)
    ) u_enc (
        .bus(enc_bus)
    );

    always_comb begin
        pend_next = raw_vec & en_vec;
        nmi_next = NMI_REQ_IN;
        num_next = enc_bus.num;
        // no depth ceiling: stack space and the global enable hold off new maskable entries
        int_req_next = enc_bus.any && i_bit_reg && STACK_AVAIL && !ENTRY_ACK;
        i_bit_next = i_bit_reg;
        depth_next = depth_reg;
        if (LOAD_PROCESSOR_REGISTER_INSTR_WR) begin
            i_bit_next = LOAD_PROCESSOR_REGISTER_INSTR_I;
        end
        if (HANDLER_RETURN) begin
            i_bit_next = RETURN_I;
            if (depth_reg != '0) begin
                depth_next = depth_reg - DEPTH_W'(1);
            end
        end
        // entry beats a same-cycle write: the new handler must start masked
        if (ENTRY_ACK) begin
            i_bit_next = 1'b0;
            depth_next = depth_reg + DEPTH_W'(1);
            if (HANDLER_RETURN) begin
                depth_next = depth_reg;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg <= `IMAP_RST_VEC;
            nmi_reg <= 1'b0;
            num_reg <= `IMAP_RST_NUM;
            int_req_reg <= 1'b0;
            i_bit_reg <= 1'b0;
            depth_reg <= '0;
        end else begin
            pend_reg <= pend_next;
            nmi_reg <= nmi_next;
            num_reg <= num_next;
            int_req_reg <= int_req_next;
            i_bit_reg <= i_bit_next;
            depth_reg <= depth_next;
        end
    end

    assign INT_REQ = int_req_reg;
    assign INT_NUM = num_reg;
    assign NMI_REQ = nmi_reg;
    assign GLOBAL_ENABLE = i_bit_reg;
    assign NEST_DEPTH = depth_reg;

    // non-maskable request ignores the global enable and the depth
    chk_nmi_always_passes: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        rst_n && NMI_REQ_IN |=> NMI_REQ)
        else $error("nmi request not forwarded");

    chk_entry_masks_next: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        ENTRY_ACK |=> !GLOBAL_ENABLE ##1 !INT_REQ)
        else $error("maskable requests not blocked after entry");

    chk_load_sets_enable: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        (rst_n && LOAD_PROCESSOR_REGISTER_INSTR_WR && LOAD_PROCESSOR_REGISTER_INSTR_I
         && !ENTRY_ACK && !HANDLER_RETURN) |=> GLOBAL_ENABLE)
        else $error("global enable not set by load write");

    chk_disabled_source_quiet: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        (en_vec == '0) ##1 (en_vec == '0) |=> !INT_REQ)
        else $error("disabled sources raised a request");

    chk_depth_counts_up: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        (rst_n && ENTRY_ACK && !HANDLER_RETURN) |=> NEST_DEPTH == $past(NEST_DEPTH) + 1'b1)
        else $error("nesting depth not advanced");

    chk_no_stack_no_req: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        !STACK_AVAIL |=> !INT_REQ)
        else $error("request raised without stack space");

    chk_uart0_map: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        $past(rst_n) |-> pend_reg[23:21] == $past({UART0_TX_REQ, UART0_CTS_REQ, CAN1_REQ}
            & SOURCE_ENABLE_HIGH[7:5]))
        else $error("uart0 or can1 mapping wrong");

    chk_uart12_map: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        $past(rst_n) |-> pend_reg[20:17] == $past({UART1_RX_REQ, UART1_TX_REQ, UART2_RX_REQ,
            UART2_TX_REQ} & SOURCE_ENABLE_HIGH[4:1]))
        else $error("uart1 or uart2 mapping wrong");

    chk_timer_map: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        $past(rst_n) |-> pend_reg[27:24] == $past({VTIMER_REQUEST_TWO, VTIMER_REQUEST_THREE,
            VTIMER_REQUEST_FOUR, SSP_REQ} & SOURCE_ENABLE_HIGH[11:8]))
        else $error("timer or serial peripheral mapping wrong");

    chk_vtimer_two_num: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        $past(pend_reg[27]) |-> INT_NUM == 5'h1B)
        else $error("timer request two not number 27");

    chk_vtimer_three_num: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        $past(pend_reg[27:26] == 2'h1) |-> INT_NUM == 5'h1A)
        else $error("timer request three not number 26");

    chk_rng_map: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        $past(rst_n) |-> pend_reg[3] == $past(RNG_REQ & SOURCE_ENABLE_LOW[3]))
        else $error("random generator mapping wrong");

    chk_rest_map: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        $past(rst_n) |-> pend_reg[16:12] == $past({UART3_RX_REQ, UART3_TX_REQ, 1'b0,
            ADC_DONE_REQ, MULTI_INPUT_WAKEUP_UNIT_REQ[0]}
            & {SOURCE_ENABLE_HIGH[0], SOURCE_ENABLE_LOW[15:12]})
        && pend_reg[31:28] == 4'h0 && pend_reg[4] == 1'b0 && pend_reg[2] == 1'b0
        && pend_reg[0] == 1'b0 && pend_reg[14] == 1'b0)
        else $error("remaining map or unused numbers wrong");
endmodule : imap_interrupt_source_map

/* core/imap_pkg.sv */
`include "imap_defines.svh"

package imap_pkg;
    typedef logic [`IMAP_NUM_W-1:0] imap_irq_num_type;
    typedef logic [`IMAP_VEC_W-1:0] imap_req_vec_type;
    typedef logic [`IMAP_DEPTH_W-1:0] imap_depth_type;
endpackage : imap_pkg

/* core/imap_prio_enc.sv */
`timescale 1ns/10ps
`include "imap_defines.svh"

// highest request number wins among pending sources
module imap_prio_enc
    import imap_pkg::*;
#(
    parameter int WIDTH = `IMAP_VEC_W
) (
    imap_enc_if.enc bus
);
    always_comb begin
        bus.any = 1'b0;
        bus.num = `IMAP_RST_NUM;
        for (int i = 0; i < WIDTH; i++) begin
            if (bus.pending[i]) begin
                bus.any = 1'b1;
                bus.num = imap_irq_num_type'(i);
            end
        end
    end
endmodule : imap_prio_enc

/* sim/imap_core_model.sv */
`timescale 1ns/10ps
// core acceptance stand-in: acks a request at once, or after a stall when slow
module imap_core_model
    import imap_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request side
    input wire logic int_req,
    input wire imap_irq_num_type int_num,
    input wire logic auto_ack,
    input wire logic slow,
    // acceptance
    output logic entry_ack,
    output logic [7:0] default_hits
);
    // reserved numbers land in the default handler
    localparam logic [31:0] RESERVED_MAP = 32'h0000_4015;
    logic [1:0] stall_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            entry_ack <= 1'b0;
            stall_reg <= 2'h0;
            default_hits <= 8'h00;
        end else begin
            entry_ack <= 1'b0;
            if (auto_ack && int_req && !entry_ack) begin
                stall_reg <= stall_reg + 2'h1;
                if (!slow || stall_reg == 2'h3) begin
                    entry_ack <= 1'b1;
                    stall_reg <= 2'h0;
                end
            end
            if (entry_ack && RESERVED_MAP[int_num]) begin
                default_hits <= default_hits + 8'h01;
            end
        end
    end
endmodule : imap_core_model

/* sim/tb.sv */
`timescale 1ns/10ps
module tb;
    import imap_pkg::*;
    localparam logic [31:0] MAPPED = 32'h0FFF_BFEA;
    logic clk, rst_n, nmi_in, ld_wr, ld_i, ret, ret_i, stack_ok, auto_ack, slow;
    logic entry_ack, int_req, nmi_req, ge, exp_ge, exp_nmi;
    logic [31:0] req, en;
    logic [7:0] hits;
    imap_irq_num_type int_num;
    imap_depth_type depth, exp_depth;
    logic [16:0] notes[$];
    int seed = 29327;
    int err_total = 0;
    int num_checks = 0;

    // source wiring follows the request numbers, so req[n] is number n
    imap_interrupt_source_map imap_interrupt_source_map_i (
        .SYS_CLK(clk), .RSTN(rst_n),
        .VTIMER_REQUEST_TWO(req[27]), .VTIMER_REQUEST_THREE(req[26]),
        .VTIMER_REQUEST_FOUR(req[25]), .SSP_REQ(req[24]),
        .UART0_TX_REQ(req[23]), .UART0_CTS_REQ(req[22]), .CAN1_REQ(req[21]),
        .UART1_RX_REQ(req[20]), .UART1_TX_REQ(req[19]),
        .UART2_RX_REQ(req[18]), .UART2_TX_REQ(req[17]),
        .UART3_RX_REQ(req[16]), .UART3_TX_REQ(req[15]), .ADC_DONE_REQ(req[13]),
        .MULTI_INPUT_WAKEUP_UNIT_REQ({req[5], req[6], req[7], req[8],
            req[9], req[10], req[11], req[12]}),
        .RNG_REQ(req[3]), .FLASH_REQ(req[1]), .NMI_REQ_IN(nmi_in),
        .SOURCE_ENABLE_LOW(en[15:0]), .SOURCE_ENABLE_HIGH(en[31:16]),
        .LOAD_PROCESSOR_REGISTER_INSTR_WR(ld_wr), .LOAD_PROCESSOR_REGISTER_INSTR_I(ld_i),
        .ENTRY_ACK(entry_ack), .HANDLER_RETURN(ret), .RETURN_I(ret_i),
        .STACK_AVAIL(stack_ok), .INT_REQ(int_req), .INT_NUM(int_num),
        .NMI_REQ(nmi_req), .GLOBAL_ENABLE(ge), .NEST_DEPTH(depth)
    );

    imap_core_model imap_core_model_i (
        .clk(clk), .rst_n(rst_n), .int_req(int_req), .int_num(int_num),
        .auto_ack(auto_ack), .slow(slow), .entry_ack(entry_ack), .default_hits(hits)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    task automatic step(input int k);
        repeat (k) @(posedge clk);
    endtask : step

    // called at a rising edge; the monitor compares after that edge settles
    task automatic note(input logic rq, input logic nv, input imap_irq_num_type num);
        notes.push_back({rq, nv, num, exp_ge, exp_nmi, exp_depth});
    endtask : note

    task automatic wait_depth(input imap_depth_type d);
        for (int i = 0; i < 40 && depth !== d; i++) @(negedge clk);
        if (depth !== d) begin
            check(depth, d);
            end_of_test();
        end else begin
            @(posedge clk);
        end
    endtask : wait_depth

    function automatic imap_irq_num_type top_bit(input logic [31:0] v);
        top_bit = 5'h00;
        for (int i = 0; i < 32; i++) if (v[i]) top_bit = i[4:0];
    endfunction : top_bit

    always @(negedge clk) begin
        logic [16:0] n;
        // a note pushed at a rising edge is due once that edge has settled
        if (notes.size() != 0) begin
            n = notes.pop_front();
            check(int_req, n[16]);
            if (n[15]) check(int_num, n[14:10]);
            check(ge, n[9]);
            check(nmi_req, n[8]);
            check(depth, n[7:0]);
        end
    end

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        {rst_n, nmi_in, ld_wr, ld_i, ret, ret_i, auto_ack, slow} = '0;
        {req, en, exp_ge, exp_nmi, exp_depth} = '0;
        stack_ok = 1'b1;
        step(2);
        rst_n <= 1'b1;
        step(3);
        note(1'b0, 1'b0, 5'h00);
        en <= 32'hFFFF_FFFF;
        ld_wr <= 1'b1;
        ld_i <= 1'b1;
        step(1);
        ld_wr <= 1'b0;
        exp_ge = 1'b1;
        note(1'b0, 1'b0, 5'h00);
        for (int n = 0; n < 32; n++) begin
            req <= 32'h0000_0001 << n;
            step(2);
            note(MAPPED[n], MAPPED[n], n[4:0]);
        end
        // random sources against random enables: masked ones must never win
        for (int n = 0; n < 24; n++) begin
            req <= $random(seed);
            en <= $random(seed);
            step(2);
            note(|(req & en & MAPPED), |(req & en & MAPPED), top_bit(req & en & MAPPED));
        end
        req <= 32'h0080_0000;
        en <= 32'hFFFF_FFFF;
        stack_ok <= 1'b0;
        step(2);
        note(1'b0, 1'b1, 5'h17);
        stack_ok <= 1'b1;
        auto_ack <= 1'b1;
        wait_depth(8'h01);
        exp_depth = 8'h01;
        exp_ge = 1'b0;
        note(1'b0, 1'b1, 5'h17);
        slow <= 1'b1;
        ld_wr <= 1'b1;
        step(1);
        ld_wr <= 1'b0;
        wait_depth(8'h02);
        exp_depth = 8'h02;
        note(1'b0, 1'b1, 5'h17);
        nmi_in <= 1'b1;
        step(1);
        exp_nmi = 1'b1;
        note(1'b0, 1'b1, 5'h17);
        nmi_in <= 1'b0;
        auto_ack <= 1'b0;
        req <= '0;
        exp_nmi = 1'b0;
        step(2);
        // the last return arrives at depth zero and must leave it there
        for (int n = 0; n < 3; n++) begin
            ret <= 1'b1;
            ret_i <= (n == 0);
            step(1);
            ret <= 1'b0;
            exp_ge = (n == 0);
            if (exp_depth != 8'h00) exp_depth--;
            note(1'b0, 1'b0, 5'h00);
            step(1);
        end
        step(2);
        // reserved numbers are never offered, so the default handler stays unused
        check(hits, 8'h00);
        end_of_test();
    end
endmodule : tb
